// ===== verilog/sync_check.sv
// Synchronism-check release logic with APB register access.
// Assumes the measurement front end presents four channel samples on pclk
// with a one-cycle valid strobe, and close requests as pin-level inputs.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sync_check #(
  parameter int lead_w = 16
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire sync_check_pkg::chan_t        bus_chan [3],
  input  wire sync_check_pkg::chan_t        line_side_voltage,
  input  wire logic                         meas_valid,
  input  wire sync_check_pkg::close_req_t   close_req,
  input  wire logic                         bypass_in,
  output logic                              sync_ok,
  output logic                              close_release,
  output logic                              irq
);
  import sync_check_pkg::*;

  // Closing-time width must fit the lead product and the read word
  if (lead_w < 8 || lead_w > 24) begin : g_lead_w_check
    $error("lead_w out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers for pin-level requests
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_r, pin_s2_r, pin_s1_nxt, pin_s2_nxt;
  always_comb begin
    pin_s1_nxt = {bypass_in, close_req.auto_init, close_req.manual};
    pin_s2_nxt = pin_s1_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]         ctrl_r, ctrl_nxt;
  logic [meas_w-1:0]   lim_mag_r, lim_mag_nxt, lim_freq_r, lim_freq_nxt;
  logic [meas_w-1:0]   lim_ph_r, lim_ph_nxt, dead_r, dead_nxt, live_r, live_nxt;
  logic [lead_w-1:0]   close_t_r, close_t_nxt;
  logic [irq_bits-1:0] irq_st_r, irq_st_nxt, mask_r, mask_nxt;
  logic [31:0]         prdata_r, prdata_nxt;
  logic                pslverr_r, pslverr_nxt;
  logic [irq_bits-1:0] status_w;
  logic [irq_bits-1:0] status_prev_r;
  logic                wr_acc;
  logic                rd_setup;
  logic                hit;

  // Address decode, zero-wait access phase; read data and error are
  // registered at the setup edge so they stand through the access phase
  always_comb begin
    wr_acc   = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    case (paddr)
      ctrl_off, lim_mag_off, lim_freq_off, lim_phase_off, close_t_off,
      dead_lvl_off, live_lvl_off, status_off, irq_off, mask_off: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Register writes, read mux and sticky interrupt bits
  always_comb begin
    ctrl_nxt     = ctrl_r;
    lim_mag_nxt  = lim_mag_r;
    lim_freq_nxt = lim_freq_r;
    lim_ph_nxt   = lim_ph_r;
    close_t_nxt  = close_t_r;
    dead_nxt     = dead_r;
    live_nxt     = live_r;
    mask_nxt     = mask_r;
    irq_st_nxt   = irq_st_r;
    prdata_nxt   = prdata_r;
    pslverr_nxt  = psel && !penable && !hit;  // Unmapped: error in access phase
    if (wr_acc) begin
      case (paddr)
        ctrl_off:      ctrl_nxt     = {21'h0, pwdata[10:0]};
        lim_mag_off:   lim_mag_nxt  = pwdata[meas_w-1:0];
        lim_freq_off:  lim_freq_nxt = pwdata[meas_w-1:0];
        lim_phase_off: lim_ph_nxt   = pwdata[meas_w-1:0];
        close_t_off:   close_t_nxt  = pwdata[lead_w-1:0];
        dead_lvl_off:  dead_nxt     = pwdata[meas_w-1:0];
        live_lvl_off:  live_nxt     = pwdata[meas_w-1:0];
        irq_off:       irq_st_nxt   = irq_st_r & ~pwdata[irq_bits-1:0];
        mask_off:      mask_nxt     = pwdata[irq_bits-1:0];
        default: ;
      endcase
    end
    if (rd_setup) begin
      case (paddr)
        ctrl_off:      prdata_nxt = ctrl_r;
        lim_mag_off:   prdata_nxt = {16'h0, lim_mag_r};
        lim_freq_off:  prdata_nxt = {16'h0, lim_freq_r};
        lim_phase_off: prdata_nxt = {16'h0, lim_ph_r};
        close_t_off:   prdata_nxt = {{(32-lead_w){1'b0}}, close_t_r};
        dead_lvl_off:  prdata_nxt = {16'h0, dead_r};
        live_lvl_off:  prdata_nxt = {16'h0, live_r};
        status_off:    prdata_nxt = {28'h0, status_w};
        irq_off:       prdata_nxt = {28'h0, irq_st_r};
        mask_off:      prdata_nxt = {28'h0, mask_r};
        default: begin
          prdata_nxt  = 32'h0;
        end
      endcase
    end
    // Rising status edges set sticky bits; set wins over clear
    irq_st_nxt = irq_st_nxt | (status_w & ~status_prev_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r        <= ctrl_rst;
      lim_mag_r     <= lim_rst;
      lim_freq_r    <= lim_rst;
      lim_ph_r      <= lim_rst;
      close_t_r     <= '0;
      dead_r        <= dead_rst;
      live_r        <= live_rst;
      mask_r        <= '0;
      irq_st_r      <= '0;
      prdata_r      <= 32'h0;
      pslverr_r     <= 1'b0;
      status_prev_r <= '0;
    end else begin
      ctrl_r        <= ctrl_nxt;
      lim_mag_r     <= lim_mag_nxt;
      lim_freq_r    <= lim_freq_nxt;
      lim_ph_r      <= lim_ph_nxt;
      close_t_r     <= close_t_nxt;
      dead_r        <= dead_nxt;
      live_r        <= live_nxt;
      mask_r        <= mask_nxt;
      irq_st_r      <= irq_st_nxt;
      prdata_r      <= prdata_nxt;
      pslverr_r     <= pslverr_nxt;
      status_prev_r <= status_w;
    end
  end

  // ----------------------------------------------------------------
  // Measurement comparison
  // ----------------------------------------------------------------
  chan_t             bus_sel;
  logic [meas_w-1:0] magnitude_delta, freq_delta, phase_delta, ph_raw;
  logic [meas_w-1:0] bus_frequency, line_frequency;
  logic [meas_w+lead_w-1:0] lead_prod;
  logic [meas_w-1:0] lead_angle;
  logic              in_lim, bus_live, bus_dead, line_live, line_dead;
  logic              ovr_hit;
  logic              gen_to_grid_mode;

  always_comb begin
    // Bus phase picked for comparison with line channel 3
    case (ctrl_r[ctl_phase_lo +: 2])
      2'd1:    bus_sel = bus_chan[1];
      2'd2:    bus_sel = bus_chan[2];
      default: bus_sel = bus_chan[0];
    endcase
    // Bus set is phase-neutral or phase-phase; levels compare alike
    bus_frequency  = bus_sel.freq;
    line_frequency = line_side_voltage.freq;
    magnitude_delta = (bus_sel.mag >= line_side_voltage.mag) ?
                      bus_sel.mag - line_side_voltage.mag :
                      line_side_voltage.mag - bus_sel.mag;
    // Absolute slip frequency
    freq_delta = (bus_frequency >= line_frequency) ?
                 bus_frequency - line_frequency : line_frequency - bus_frequency;
    ph_raw = bus_sel.phase - line_side_voltage.phase;
    phase_delta = (ph_raw >= half_turn) ? 16'h0 - ph_raw : ph_raw;
    // Angle travelled during closing time: slip (turn/us code) times time
    lead_prod  = freq_delta * close_t_r;
    lead_angle = (|lead_prod[meas_w+lead_w-1:meas_w]) ? 16'hffff : lead_prod[meas_w-1:0];
    gen_to_grid_mode = ctrl_r[ctl_mode];
    // Grid mode checks angle directly, generator mode centres the window on the lead angle
    if (gen_to_grid_mode) begin
      in_lim = (magnitude_delta <= lim_mag_r) && (freq_delta <= lim_freq_r) &&
               ({1'b0, phase_delta} <= {1'b0, lim_ph_r} + {1'b0, lead_angle}) &&
               (phase_delta >= ((lead_angle > lim_ph_r) ? lead_angle - lim_ph_r : 16'h0));
    end else begin
      in_lim = (magnitude_delta <= lim_mag_r) && (freq_delta <= lim_freq_r) &&
               (phase_delta <= lim_ph_r);
    end
    // Dead or live on each side from the selected bus phase and the line
    bus_live  = bus_sel.mag >= live_r;
    bus_dead  = bus_sel.mag <= dead_r;
    line_live = line_side_voltage.mag >= live_r;
    line_dead = line_side_voltage.mag <= dead_r;
    ovr_hit = (ctrl_r[ctl_en_live_bus_dead_line] && bus_live && line_dead) ||
              (ctrl_r[ctl_en_dead_bus_live_line] && bus_dead && line_live) ||
              (ctrl_r[ctl_en_dead_bus_dead_line] && bus_dead && line_dead);
  end

  // ----------------------------------------------------------------
  // Decision registers
  // ----------------------------------------------------------------
  logic sync_r, sync_nxt, ovr_r, ovr_nxt, rel_r, rel_nxt, irq_r, irq_nxt;
  logic supervised;

  always_comb begin
    // All three in limits at once, dropped on the first miss
    sync_nxt = meas_valid ? (ctrl_r[ctl_enable] && in_lim) : sync_r;
    ovr_nxt  = meas_valid ? (ctrl_r[ctl_enable] && ovr_hit) : ovr_r;
    // Besides bypass, only requests chosen for supervision can release while enabled
    supervised = (ctrl_r[ctl_sup_man] && pin_s2_r[0]) ||
                 (ctrl_r[ctl_sup_auto] && pin_s2_r[1]);
    // Bypass forces release; its source must ensure synchronism
    rel_nxt = pin_s2_r[2] ||
              (supervised && (sync_nxt || ovr_nxt)) ||
              (!ctrl_r[ctl_enable] && (pin_s2_r[0] || pin_s2_r[1]));
    status_w = {pin_s2_r[2], ovr_r, rel_r, sync_r};
    irq_nxt  = |(irq_st_nxt & ~mask_r);  // A set mask bit blocks its event
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 1'b0;
      ovr_r  <= 1'b0;
      rel_r  <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      ovr_r  <= ovr_nxt;
      rel_r  <= rel_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = 1'b1;
  assign pslverr       = pslverr_r;
  assign sync_ok       = sync_r;
  assign close_release = rel_r;
  assign irq           = irq_r;

endmodule
`default_nettype wire

// ===== verilog/sync_check_pkg.sv
// Package for the synchronism-check release logic: register map, field layouts, types.
// Assumes an APB slave with 32-bit data and one clock, pclk at 100 MHz.
// Functional notes
// - Channels 0..2 are bus, channel 3 line
// - Setting picks bus phase for line comparison
// - Bus set may be phase-neutral or phase-phase
// - Slip is absolute bus minus line frequency
// - Synchronous only when all three inside limits
// - Generator mode advances release by closing time
// - Grid mode checks without any advance
// - Supervise manual, automatic or both close requests
// - Enabled dead/live overrides release regardless of sync
// - External bypass forces release; bypasser ensures sync
package sync_check_pkg;

  // --------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ctrl_off      = 8'h00;
  localparam logic [7:0] lim_mag_off   = 8'h04;
  localparam logic [7:0] lim_freq_off  = 8'h08;
  localparam logic [7:0] lim_phase_off = 8'h0c;
  localparam logic [7:0] close_t_off   = 8'h10;
  localparam logic [7:0] dead_lvl_off  = 8'h14;
  localparam logic [7:0] live_lvl_off  = 8'h18;
  localparam logic [7:0] status_off    = 8'h1c;
  localparam logic [7:0] irq_off       = 8'h20;
  localparam logic [7:0] mask_off      = 8'h24;

  // --------------------------------------------------------------
  // Control field positions and reset values
  // --------------------------------------------------------------
  localparam int ctl_enable    = 0;
  localparam int ctl_mode      = 1;  // 1 = gen_to_grid_mode, 0 = grid_to_grid_mode
  localparam int ctl_sup_man   = 2;
  localparam int ctl_sup_auto  = 3;
  localparam int ctl_en_live_bus_dead_line   = 4;
  localparam int ctl_en_dead_bus_live_line   = 5;
  localparam int ctl_en_dead_bus_dead_line   = 6;
  localparam int ctl_phase_lo  = 8;  // Two bits: bus phase compared with line
  localparam int ctl_ph2ph     = 10; // Bus set is phase-to-phase
  localparam logic [31:0] ctrl_rst = 32'h0000_000f;

  // Status and interrupt bits
  localparam int st_sync    = 0;
  localparam int st_release = 1;
  localparam int st_ovr     = 2;
  localparam int st_bypass  = 3;
  localparam int irq_bits   = 4;

  localparam int meas_w  = 16;
  localparam logic [meas_w-1:0] lim_rst = 16'h0010;
  localparam logic [meas_w-1:0] dead_rst = 16'h0100;
  localparam logic [meas_w-1:0] live_rst = 16'h0800;
  // Phase is an unsigned full-turn code; 16'h8000 is half a turn
  localparam logic [meas_w-1:0] half_turn = 16'h8000;

  // Time units: closing time register counts in microseconds
  localparam int clk_mhz    = 100;
  localparam int us_ns      = 1000;
  localparam int clk_ns     = 10;
  localparam int cyc_per_us = us_ns / clk_ns;

  // One voltage channel sample
  typedef struct packed {
    logic [meas_w-1:0] mag;
    logic [meas_w-1:0] phase;
    logic [meas_w-1:0] freq;
  } chan_t;

  typedef struct packed {
    logic manual;
    logic auto_init;  // Automatically initiated close request
  } close_req_t;

endpackage

// ===== tb/sync_check_monitor.sv
// Port-level checker for sync_check.
// Assumes a bind to sync_check; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sync_check_monitor (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       meas_valid,
  input wire sync_check_pkg::close_req_t close_req,
  input wire logic                       bypass_in,
  input wire logic                       sync_ok,
  input wire logic                       close_release
);
  import sync_check_pkg::*;
  logic [5:0] cause_r;
  logic [5:0] cause_nxt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // History of release causes
  always_comb begin
    cause_nxt = {cause_r[4:0], bypass_in | close_req.manual | close_req.auto_init};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= 6'h00;
    end else begin
      cause_r <= cause_nxt;
    end
  end
  sequence byp_held; bypass_in [*5]; endsequence
  sequence no_cause; (!bypass_in && close_req == 2'b00) [*6]; endsequence
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access not answered");
  bad_addr_a: assert property (psel && penable && paddr > mask_off |-> pslverr)
    else $error("unmapped access not refused");
  err_pulse_a: assert property (pslverr |=> !pslverr)
    else $error("error response too long");
  bad_rdata_a: assert property (psel && penable && !pwrite && paddr > mask_off |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  bypass_force_a: assert property (byp_held |-> close_release)
    else $error("bypass did not release");
  sync_sample_a: assert property ($changed(sync_ok) |-> $past(meas_valid))
    else $error("sync changed without sample");
  release_cause_a: assert property ($rose(close_release) |-> cause_r != 6'h00)
    else $error("release without cause");
  release_idle_a: assert property (no_cause |-> !close_release)
    else $error("release held without cause");
endmodule
`default_nettype wire

// ===== tb/meas_src.sv
// Model of the measurement front end and breaker close control.
// Assumes the bench calls its tasks; samples go out every four cycles.
`timescale 1ns/1ps
`default_nettype none
module meas_src (
  input  wire logic                      pclk,
  output var sync_check_pkg::chan_t      bus_chan [3],
  output var sync_check_pkg::chan_t      line_side_voltage,
  output logic                           meas_valid,
  output var sync_check_pkg::close_req_t close_req,
  output logic                           bypass_in
);
  import sync_check_pkg::*;
  chan_t      bus_v [3];
  chan_t      line_v;
  logic [1:0] cnt;
  // Quiet start
  initial begin
    cnt = 2'h0;
    meas_valid = 1'b0;
    close_req = 2'b00;
    bypass_in = 1'b0;
    bus_v = '{default: '0};
    line_v = '0;
    bus_chan = '{default: '0};
    line_side_voltage = '0;
  end
  // Fresh sample set with a one-cycle strobe
  always @(posedge pclk) begin
    cnt <= cnt + 2'h1;
    meas_valid <= (cnt == 2'h3);
    bus_chan <= bus_v;
    line_side_voltage <= line_v;
  end
  // All three bus phases alike; the bench may skew one afterwards
  task set_meas(input chan_t b, input chan_t l);
    @(posedge pclk);
    bus_v <= '{b, b, b};
    line_v <= l;
  endtask
  // Close request and bypass levels; a bypasser must ensure synchronism
  task set_pins(input logic m, input logic a, input logic b);
    @(posedge pclk);
    close_req <= '{manual: m, auto_init: a};
    bypass_in <= b;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for sync_check.
// Assumes the package, meas_src and sync_check_monitor compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sync_check_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic meas_valid, bypass_in, sync_ok, close_release, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  chan_t bus_chan [3];
  chan_t line_side_voltage;
  close_req_t close_req;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  chan_t base = '{mag: 16'h0900, phase: 16'h1000, freq: 16'h4000};
  sync_check i_sync_check (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_chan(bus_chan), .line_side_voltage(line_side_voltage),
    .meas_valid(meas_valid), .close_req(close_req), .bypass_in(bypass_in),
    .sync_ok(sync_ok), .close_release(close_release), .irq(irq));
  meas_src i_meas_src (.pclk(pclk), .bus_chan(bus_chan), .line_side_voltage(line_side_voltage),
    .meas_valid(meas_valid), .close_req(close_req), .bypass_in(bypass_in));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  task test_done;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data and error are taken at the edge where pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task look;
    repeat (10) @(posedge pclk);
    @(negedge pclk);
  endtask
  function automatic chan_t addc(input chan_t a, input logic [47:0] o);
    chan_t r;
    r.mag = a.mag + o[47:32];
    r.phase = a.phase + o[31:16];
    r.freq = a.freq + o[15:0];
    return r;
  endfunction
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_regs;
    logic [7:0] a [5] = '{ctrl_off, lim_mag_off, close_t_off, dead_lvl_off, live_lvl_off};
    logic [31:0] e [5] = '{32'hf, 32'h10, 32'h0, 32'h100, 32'h800};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, e[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_limits;
    logic [47:0] off [8] = '{48'h0, 48'h20_0000_0000, 48'h8_0000_0000, 48'h20,
                             48'hffe0, 48'hfff8, 48'h20_0000, 48'h8_0000};
    logic [7:0] ok = 8'b1010_0101;
    apb(1'b1, ctrl_off, 32'h0d);
    for (int i = 0; i < 8; i++) begin
      i_meas_src.set_meas(base, addc(base, off[i]));
      look;
      chk(sync_ok, ok[i]);
    end
  endtask
  task t_mode;
    i_meas_src.set_meas(base, addc(base, 48'h4));
    apb(1'b1, close_t_off, 32'h10);
    look;
    chk(sync_ok, 32'h1);
    apb(1'b1, ctrl_off, 32'h0f);
    look;
    chk(sync_ok, 32'h0);
    apb(1'b1, close_t_off, 32'h0);
    look;
    chk(sync_ok, 32'h1);
  endtask
  task t_sel;
    i_meas_src.set_meas(base, base);
    @(posedge pclk);
    i_meas_src.bus_v[1].phase <= 16'h1040;
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, ctrl_off, 32'h0d | (32'(s) << 8));
      look;
      chk(sync_ok, 32'(s != 1));
    end
  endtask
  task t_close;
    i_meas_src.set_meas(base, base);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ctrl_off, k ? 32'h09 : 32'h05);
      for (int r = 1; r < 3; r++) begin
        i_meas_src.set_pins(r[1], r[0], 1'b0);
        look;
        chk(close_release, 32'((k == 0) == (r == 2)));
      end
    end
  endtask
  task t_ovr;
    chan_t b;
    chan_t l;
    for (int j = 0; j < 3; j++) begin
      b = base;
      l = addc(base, 48'h40_0000);
      if (j > 0) b.mag = 16'h0;
      if (j != 1) l.mag = 16'h0;
      i_meas_src.set_meas(b, l);
      for (int e = 0; e < 2; e++) begin
        apb(1'b1, ctrl_off, 32'h0d | (32'(e) << (4 + j)));
        look;
        chk(close_release, 32'(e));
      end
    end
    apb(1'b1, ctrl_off, 32'h0d);
    apb(1'b1, mask_off, 32'h0);
    i_meas_src.set_pins(1'b0, 1'b0, 1'b0);
    look;
    apb(1'b1, irq_off, 32'hf);
    i_meas_src.set_pins(1'b0, 1'b0, 1'b1);
    look;
    chk(close_release, 32'h1);
    chk(irq, 32'h1);
    apb(1'b0, irq_off, 32'h0);
    chk(rd[3], 32'h1);
    apb(1'b1, mask_off, 32'hf);
    look;
    chk(irq, 32'h0);
    apb(1'b1, mask_off, 32'h0);
    look;
    chk(irq, 32'h1);
    apb(1'b1, irq_off, 32'hf);
    look;
    chk(irq, 32'h0);
    i_meas_src.set_pins(1'b0, 1'b0, 1'b0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_limits;
    t_mode;
    t_sel;
    t_close;
    t_ovr;
    test_done;
  end
endmodule
bind sync_check sync_check_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .meas_valid(meas_valid), .close_req(close_req), .bypass_in(bypass_in),
  .sync_ok(sync_ok), .close_release(close_release));
`default_nettype wire
